// ---- ets_map.svh ----
// Register map, field positions and reset values of the frame timestamper.
// Assumes byte addressing on a 32-bit APB bus, one aligned word per register.
`ifndef ETS_MAP_SVH
`define ETS_MAP_SVH
// ==========================================================================
// Register offsets
`define ETS_OFS_CTRL     8'h00
`define ETS_OFS_EVENT    8'h04
`define ETS_OFS_MASK     8'h08
`define ETS_OFS_TXSTAMP  8'h0C
`define ETS_OFS_TIMER    8'h10
// ==========================================================================
// Field positions
`define ETS_BIT_ENABLE   0
`define ETS_BIT_AVAIL    0
`define ETS_BIT_RXSTAMP  1
`define ETS_BIT_TS_REQ   5
`define ETS_EVENT_W      2
// ==========================================================================
// Reset values and constants
`define ETS_RST_WORD     32'h0000_0000
`define ETS_RST_EVENT    2'h0
`define ETS_RST_TAG      4'h0
`define ETS_TAG_STEP     4'h1
`define ETS_TIMER_STEP   32'h0000_0001
`endif

// ---- ets_pkg.sv ----
// Types shared by the timestamper modules.
// Assumes ets_map.svh supplies all widths of the event field.
`include "ets_map.svh"
package ets_pkg;
  // ========================================================================
  // Register selector
  typedef enum {
    ETS_SEL_CTRL, ETS_SEL_EVENT, ETS_SEL_MASK, ETS_SEL_TXSTAMP, ETS_SEL_TIMER, ETS_SEL_NONE
  } ets_sel_t;
  // ========================================================================
  // Timer state
  typedef struct packed {
    logic [31:0] count;
  } ets_tmr_t;
  // ========================================================================
  // Timestamper state
  typedef struct packed {
    logic                    enable;
    logic [`ETS_EVENT_W-1:0] event_flags;
    logic [`ETS_EVENT_W-1:0] mask;
    logic [31:0]             cap_stamp;
    logic [31:0]             tx_hold;
    logic                    tx_hold_req;
    logic [3:0]              seq;
    logic                    tx_valid;
    logic [31:0]             tx_value;
    logic [3:0]              tx_tag;
    logic [7:0]              tx_status;
    logic                    rx_valid;
    logic [31:0]             rx_value;
    logic                    irq;
    logic                    pready;
    logic [31:0]             prdata;
    logic                    pslverr;
  } ets_state_t;
endpackage : ets_pkg

// ---- ets_timer.sv ----
// Free-running 32-bit time base of the timestamper.
// Assumes one clock domain; the count only moves while enabled.
`timescale 1ns/100ps
module ets_timer
  import ets_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        enable,
  output logic [31:0]      count
);
  ets_tmr_t r;
  ets_tmr_t n;

  // ========================================================================
  // Count step, frozen while the time function is off
  always_comb begin
    n = r;
    if (enable) begin
      n.count = r.count + `ETS_TIMER_STEP; // [R10]
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign count = r.count;

  // ========================================================================
  // Checks
  a_timer_steps: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    enable |=> count == $past(count) + `ETS_TIMER_STEP)
    else $error("timer did not advance while enabled");
  a_timer_holds: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    !enable |=> $stable(count))
    else $error("timer moved while disabled");
endmodule : ets_timer

// ---- ets_top.sv ----
// Precise-time stamping beside an Ethernet MAC: transmit and receive stamps,
// a captured transmit stamp register and two event flags with interrupt, on APB.
// Assumes tx/rx strobes are one-cycle pulses synchronous to pclk.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
// Behaviour
// R1: Stamping and timer run only while the enable control bit is one.
// R2: Client asserts stamp request only with time-sync event frames.
// R3: Each transmitted frame returns 32-bit stamp, 4-bit tag and status.
// R4: Returned status bit 5 equals the frame's stamp request.
// R5: Requested frames store stamp in captured register and set available flag.
// R6: Software waits for available flag, then reads captured stamp register.
// R7: Unrequested frames leave captured register and available flag untouched.
// R8: Timer latched at receive delimiter detection, shown on receive stamp output.
// R9: Receive DMA copies each receive stamp into that frame's descriptor.
// R10: One free-running 32-bit counter, gated by enable, feeds all stamps.
module ets_top
  import ets_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Transmit client side
  input  wire logic        tx_frame_start,
  input  wire logic        tx_stamp_request,
  input  wire logic        tx_frame_done,
  input  wire logic [7:0]  tx_mac_status,
  output logic             tx_stamp_valid,
  output logic [31:0]      tx_stamp_value,
  output logic [3:0]       tx_stamp_seq_tag,
  output logic [7:0]       tx_stamp_status,
  // Receive side
  input  wire logic        rx_sfd_seen,
  output logic             rx_stamp_valid,
  output logic [31:0]      rx_stamp_value,
  // Interrupt
  output logic             irq
);
  ets_state_t  r;
  ets_state_t  n;
  logic [31:0] now;

  // ========================================================================
  // Register decode, shared by read and write paths
  function automatic ets_sel_t reg_sel(input logic [7:0] a);
    case (a)
      `ETS_OFS_CTRL:    reg_sel = ETS_SEL_CTRL;
      `ETS_OFS_EVENT:   reg_sel = ETS_SEL_EVENT;
      `ETS_OFS_MASK:    reg_sel = ETS_SEL_MASK;
      `ETS_OFS_TXSTAMP: reg_sel = ETS_SEL_TXSTAMP;
      `ETS_OFS_TIMER:   reg_sel = ETS_SEL_TIMER;
      default:          reg_sel = ETS_SEL_NONE;
    endcase
  endfunction : reg_sel

  // ========================================================================
  // Time base
  ets_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (r.enable),
    .count   (now)
  );

  // ========================================================================
  // Next-state logic
  always_comb begin
    logic                    setup;
    logic                    done;
    logic                    ts_start_req;
    logic [31:0]             ts_start_val;
    logic [`ETS_EVENT_W-1:0] ev_set;
    logic [`ETS_EVENT_W-1:0] ev_clr;
    logic [31:0]             rd;
    ets_sel_t                sel;
    // Every scratch value is set first, so no latch is inferred
    setup        = psel && !penable;
    done         = psel && penable && r.pready;
    sel          = reg_sel(paddr);
    ev_set       = '0;
    ev_clr       = '0;
    rd           = `ETS_RST_WORD;
    ts_start_req = 1'b0;
    ts_start_val = `ETS_RST_WORD;
    n            = r;
    n.tx_valid   = 1'b0;
    n.rx_valid   = 1'b0;

    // Transmit: stamp taken at frame start, reported at frame end
    if (r.enable && tx_frame_start) begin // [R1]
      n.tx_hold     = now; // [R10]
      n.tx_hold_req = tx_stamp_request;
    end
    // A frame whose start and done share one cycle uses this cycle's values directly
    ts_start_req = tx_frame_start ? tx_stamp_request : r.tx_hold_req;
    ts_start_val = tx_frame_start ? now : r.tx_hold;
    if (r.enable && tx_frame_done) begin // [R1]
      n.tx_valid  = 1'b1; // [R3]
      n.tx_value  = ts_start_val;
      n.tx_tag    = r.seq;
      n.seq       = r.seq + `ETS_TAG_STEP;
      n.tx_status = tx_mac_status;
      n.tx_status[`ETS_BIT_TS_REQ] = ts_start_req; // [R4]
      // Only requested frames touch the captured stamp, so a pending one survives
      if (ts_start_req) begin // [R7]
        n.cap_stamp = ts_start_val; // [R5]
        ev_set[`ETS_BIT_AVAIL] = 1'b1; // [R5]
      end
    end

    // Receive: timer latched on the delimiter
    if (r.enable && rx_sfd_seen) begin // [R1]
      n.rx_valid = 1'b1;
      n.rx_value = now; // [R8]
      ev_set[`ETS_BIT_RXSTAMP] = 1'b1;
    end

    // APB: data prepared in setup, one wait-free access cycle follows
    n.pready = setup;
    case (sel)
      ETS_SEL_CTRL:    rd[`ETS_BIT_ENABLE] = r.enable;
      ETS_SEL_EVENT:   rd[`ETS_EVENT_W-1:0] = r.event_flags;
      ETS_SEL_MASK:    rd[`ETS_EVENT_W-1:0] = r.mask;
      ETS_SEL_TXSTAMP: rd = r.cap_stamp;
      ETS_SEL_TIMER:   rd = now;
      default:         rd = `ETS_RST_WORD;
    endcase
    if (setup) begin
      n.prdata  = pwrite ? `ETS_RST_WORD : rd;
      n.pslverr = (sel == ETS_SEL_NONE);
    end
    // Writes land at the access edge; read-only words drop them without error
    if (done && pwrite) begin
      case (sel)
        ETS_SEL_CTRL: n.enable = pwdata[`ETS_BIT_ENABLE];
        ETS_SEL_MASK: n.mask = pwdata[`ETS_EVENT_W-1:0];
        default:      n.mask = r.mask;
      endcase
    end
    // Clear only the bits software was shown, so a newer event is not lost
    if (done && !pwrite && sel == ETS_SEL_EVENT) begin
      ev_clr = r.prdata[`ETS_EVENT_W-1:0];
    end
    // Set beats clear, so an event on the clearing read's edge survives
    n.event_flags = (r.event_flags & ~ev_clr) | ev_set;
    // Irq is formed from the next flags, so it changes with them, yet leaves a flop, as every output must
    n.irq         = |(n.event_flags & r.mask);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ========================================================================
  // Outputs straight from state flops
  assign pready           = r.pready;
  assign prdata           = r.prdata;
  assign pslverr          = r.pslverr;
  assign tx_stamp_valid   = r.tx_valid;
  assign tx_stamp_value   = r.tx_value;
  assign tx_stamp_seq_tag = r.tx_tag;
  assign tx_stamp_status  = r.tx_status;
  assign rx_stamp_valid   = r.rx_valid;
  assign rx_stamp_value   = r.rx_value;
  assign irq              = r.irq;

  // ========================================================================
  // Checks
  // Transmit reports, status and sequence tags
  a_tx_off_silent: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    !r.enable |=> !tx_stamp_valid && !rx_stamp_valid)
    else $error("stamp reported while disabled");
  a_tx_every_frame: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    r.enable && tx_frame_done |=> tx_stamp_valid && tx_stamp_seq_tag == $past(r.seq))
    else $error("transmitted frame got no stamp report");
  a_tag_advance: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    r.enable && tx_frame_done |=> r.seq == $past(r.seq) + `ETS_TAG_STEP)
    else $error("sequence tag did not advance");
  a_tag_holds: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    !(r.enable && tx_frame_done) |=> $stable(r.seq))
    else $error("sequence tag moved without a frame");
  a_status_bit: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    r.enable && tx_frame_start && !tx_frame_done ##1 r.enable && !tx_frame_start && tx_frame_done
    |=> tx_stamp_status[`ETS_BIT_TS_REQ] == $past(tx_stamp_request, 2))
    else $error("status request bit wrong");
  a_status_same: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    r.enable && tx_frame_start && tx_frame_done
    |=> tx_stamp_status[`ETS_BIT_TS_REQ] == $past(tx_stamp_request))
    else $error("status request bit wrong for a one-cycle frame");
  // Captured stamp and stamp-available flag
  a_avail_set: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    tx_stamp_valid && tx_stamp_status[`ETS_BIT_TS_REQ]
    |-> r.event_flags[`ETS_BIT_AVAIL] && r.cap_stamp == tx_stamp_value)
    else $error("requested stamp not captured");
  a_cap_kept: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    tx_stamp_valid && !tx_stamp_status[`ETS_BIT_TS_REQ] |-> $stable(r.cap_stamp))
    else $error("unrequested frame changed captured stamp");
  a_cap_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    !(r.enable && tx_frame_done) |=> $stable(r.cap_stamp))
    else $error("captured stamp changed without a frame");
  a_flag_rise: assert property (@(posedge pclk) disable iff (!presetn) // [R5] [R7]
    $rose(r.event_flags[`ETS_BIT_AVAIL]) |-> tx_stamp_valid && tx_stamp_status[`ETS_BIT_TS_REQ])
    else $error("stamp-available flag set without a requested frame");
  // Receive stamp and interrupt
  a_rx_latch: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    r.enable && rx_sfd_seen |=> rx_stamp_valid && rx_stamp_value == $past(now))
    else $error("receive stamp not latched from timer");
  a_rx_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    r.enable && rx_sfd_seen |=> r.event_flags[`ETS_BIT_RXSTAMP])
    else $error("receive stamp event not flagged");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(n.event_flags) & $past(r.mask)))
    else $error("interrupt level mismatch");
endmodule : ets_top

// ---- ets_client.sv ----
// Partner model: transmit frame client and receive DMA descriptor writer.
// Assumes the bench pulses go and rx_go for one pclk cycle after a rising edge.
`timescale 1ns/100ps
module ets_client
  import ets_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic        req,
  input  wire logic [1:0]  gap,
  input  wire logic [7:0]  stat,
  input  wire logic        rx_go,
  input  wire logic        rx_stamp_valid,
  input  wire logic [31:0] rx_stamp_value,
  output logic             tx_frame_start,
  output logic             tx_stamp_request,
  output logic             tx_frame_done,
  output logic [7:0]       tx_mac_status,
  output logic             rx_sfd_seen,
  output logic [31:0]      desc_stamp
);
  logic [1:0] cnt_r;
  logic       fin;

  // ==========================================================================
  // Frame sequencing
  // Done comes gap cycles after start; gap of zero puts both in one cycle
  assign fin = (go && gap == 2'h0) || (cnt_r == 2'h1);
  // Idle request and status toggle, so a stale sample never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tx_frame_start, tx_stamp_request, tx_frame_done, rx_sfd_seen} <= 4'h0;
      {tx_mac_status, cnt_r, desc_stamp} <= 42'h0;
    end else begin
      tx_frame_start <= go;
      tx_stamp_request <= go ? req : ~tx_stamp_request;
      cnt_r <= go ? gap : (cnt_r != 2'h0 ? cnt_r - 2'h1 : 2'h0);
      tx_frame_done <= fin;
      tx_mac_status <= fin ? stat : ~tx_mac_status;
      rx_sfd_seen <= rx_go;
      if (rx_stamp_valid) begin
        desc_stamp <= rx_stamp_value;
      end
    end
  end
endmodule : ets_client

// ---- test_ethernet_frame_timestamper.sv ----
// Self-checking bench of the frame timestamper with random frames.
// Assumes ets_top and ets_client; APB answers after one access cycle.
`timescale 1ns/100ps
`define CHK(a, b) begin \
  check_count++; \
  if ((a) !== (b)) begin \
    n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
  end \
end
module test_ethernet_frame_timestamper;
  import ets_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, go, req, rx_go;
  logic        pready, pslverr, st, sr, fd, sfd, tv, rv_ok, irq, pend, m, got, e;
  logic [1:0]  gap;
  logic [3:0]  tag;
  logic [7:0]  paddr, stat, ms, ts;
  logic [31:0] pwdata, prdata, tx_v, rv, desc, rd, vb, cap;
  int          n_errors, check_count, cyc, t0, tb;

  ets_top ets_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tx_frame_start(st), .tx_stamp_request(sr), .tx_frame_done(fd),
    .tx_mac_status(ms), .tx_stamp_valid(tv), .tx_stamp_value(tx_v), .tx_stamp_seq_tag(tag),
    .tx_stamp_status(ts), .rx_sfd_seen(sfd), .rx_stamp_valid(rv_ok), .rx_stamp_value(rv),
    .irq(irq));
  ets_client ets_client_i (.pclk(pclk), .presetn(presetn), .go(go), .req(req), .gap(gap),
    .stat(stat), .rx_go(rx_go), .rx_stamp_valid(rv_ok), .rx_stamp_value(rv),
    .tx_frame_start(st), .tx_stamp_request(sr), .tx_frame_done(fd), .tx_mac_status(ms),
    .rx_sfd_seen(sfd), .desc_stamp(desc));

  // ==========================================================================
  // Clock and cycle count
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // ==========================================================================
  // Tasks
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 8);
    rd = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    if (pready !== 1'h1) begin
      n_errors++;
      conclude();
    end
  endtask : apb

  // One frame through the client; got tells whether a report came back
  task automatic frame(input logic r, input logic [1:0] g, input logic rx);
    int k;
    @(posedge pclk);
    {go, req, gap, rx_go, stat} <= {1'h1, r, g, rx, 8'($urandom)};
    t0 = cyc;
    @(posedge pclk);
    {go, rx_go} <= 2'h0;
    got = 1'h0;
    for (k = 0; k < 10 && !got; k++) begin
      @(negedge pclk);
      got = (tv === 1'h1);
    end
  endtask : frame

  // ==========================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, go, req, gap, rx_go, stat} = '0;
    {presetn, n_errors, check_count} = '0;
    rd = $urandom(32'h5494);
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    // Reset values, then the unmapped word just past the map
    for (int a = 0; a < 6; a++) begin
      apb(1'h0, 8'(a * 4), 32'h0);
      `CHK(rd, 32'h0)
      `CHK(e, a == 5)
    end
    frame(1'h1, 2'h1, 1'h0);
    `CHK(got, 1'h0)
    apb(1'h1, 8'h00, 32'h1);
    {pend, cap} = '0;
    // Random frames, random mask; first one is start and done together
    for (int i = 0; i < 18; i++) begin
      m = 1'($urandom);
      apb(1'h1, 8'h08, {30'h0, 1'h0, m});
      frame(i == 0 || 1'($urandom), i == 0 ? 2'h0 : 2'($urandom), 1'h0);
      `CHK(got, 1'h1)
      `CHK(ts, {stat[7:6], req, stat[4:0]})
      `CHK(tag, 4'(i))
      if (i == 0) {vb, tb} = {tx_v, t0};
      `CHK(tx_v - vb, 32'(t0 - tb))
      if (req) {cap, pend} = {tx_v, 1'h1};
      @(negedge pclk);
      `CHK(irq, pend & m)
      // Software side: look at the flag first, then fetch the captured stamp
      apb(1'h0, 8'h04, 32'h0);
      `CHK(rd, {31'h0, pend})
      apb(1'h0, 8'h0C, 32'h0);
      `CHK(rd, cap)
      pend = 1'h0;
    end
    // Receive delimiter in the same cycle as a transmit start
    frame(1'h0, 2'h2, 1'h1);
    `CHK(rv, tx_v)
    `CHK(desc, rv)
    apb(1'h0, 8'h04, 32'h0);
    `CHK(rd, 32'h2)
    // Captured stamp is read-only
    apb(1'h1, 8'h0C, 32'hFFFF_FFFF);
    apb(1'h0, 8'h0C, 32'h0);
    `CHK(rd, cap)
    // Disabled again: timer frozen, no reports
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    vb = rd;
    frame(1'h1, 2'h0, 1'h0);
    `CHK(got, 1'h0)
    apb(1'h0, 8'h10, 32'h0);
    `CHK(rd, vb)
    conclude();
  end
endmodule : test_ethernet_frame_timestamper
